/* File: mosd_pkg.sv */
`default_nettype none
package mosd_pkg;

  // ****************************************************************
  // Output selection and run modes
  // ****************************************************************
  localparam logic [2:0] OSEL_I2C   = 3'h1;
  localparam logic [2:0] OSEL_SPI   = 3'h3;
  localparam logic [2:0] OSEL_PDMC  = 3'h4;
  localparam logic [2:0] OSEL_PDMCT = 3'h6;

  // ****************************************************************
  // Status codes and result layout
  // ****************************************************************
  localparam logic [1:0]  STAT_VALID = 2'h0;
  localparam logic [1:0]  STAT_STALE = 2'h1;
  localparam logic [1:0]  STAT_CMD   = 2'h2;
  localparam int          RES_W      = 14;
  localparam int          PKT_W      = 32;
  localparam logic [13:0] RES_SAT    = 14'h3fff;
  localparam logic [13:0] RES_ZERO   = 14'h0000;

  // ****************************************************************
  // Nonvolatile store geometry
  // ****************************************************************
  localparam int NV_WORDS = 32;
  localparam int NV_DW    = 16;
  localparam int NV_PW    = 6;
  localparam int NV_CW    = NV_DW + NV_PW;
  localparam int NV_AW    = 5;

  // ****************************************************************
  // Density output divider
  // ****************************************************************
  localparam int          PDM_DIV     = 4;
  localparam logic [2:0]  PDM_DIV_MAX = 3'(PDM_DIV - 1);

  typedef enum logic [2:0] {
    ST_BOOT   = 3'b000,
    ST_IDLE   = 3'b001,
    ST_CHECK  = 3'b010,
    ST_TEMP   = 3'b011,
    ST_CAP    = 3'b100,
    ST_CORR   = 3'b101,
    ST_UPDATE = 3'b110
  } mosd_state_e;

endpackage : mosd_pkg
`default_nettype wire

/* File: mosd_nvm.sv */
`timescale 1ns/100ps
`default_nettype none
module mosd_nvm
  import mosd_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Read port
  input  wire logic [NV_AW-1:0]  rd_addr,
  input  wire logic              rd_en,
  // Write port
  input  wire logic [NV_AW-1:0]  wr_addr,
  input  wire logic              wr_en,
  input  wire logic [NV_CW-1:0]  wr_word,
  // Registered read data
  output logic      [NV_CW-1:0]  rd_word
);

  // ****************************************************************
  // Protected word store, data and check bits side by side
  // ****************************************************************
  logic [NV_CW-1:0] mem [NV_WORDS];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_word;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rd_word <= '0;
    end
    else if (rd_en)
    begin
      rd_word <= mem[rd_addr];
    end
  end

endmodule : mosd_nvm
`default_nettype wire

/* File: mosd_ecc.sv */
`timescale 1ns/100ps
`default_nettype none
module mosd_ecc
  import mosd_pkg::*;
(
  // Stored word in
  input  wire logic [NV_CW-1:0] code_in,
  // Corrected data and flags
  output logic      [NV_DW-1:0] data_out,
  output logic                  single_bit_fix,
  output logic                  double_bit_flag
);

  // ****************************************************************
  // Hamming check over 21 positions plus overall parity
  // ****************************************************************
  logic [21:1] cw;
  logic [4:0]  syn;
  logic        ovr;

  always_comb
  begin
    cw       = code_in[20:0];
    syn      = '0;
    ovr      = ^code_in;
    for (int i = 1; i <= 21; i++)
    begin
      if (cw[i])
      begin
        syn = syn ^ 5'(i);
      end
    end
    if (syn != 5'h00 && !ovr)
    begin
      syn = syn;
    end
    else if (ovr && syn != 5'h00 && syn <= 5'd21)
    begin
      cw[syn] = ~cw[syn];
    end
    single_bit_fix  = ovr;
    double_bit_flag = (syn != 5'h00) && !ovr;
    data_out = {cw[21], cw[20:17], cw[15:9], cw[7:5], cw[3]};
  end

endmodule : mosd_ecc
`default_nettype wire

/* File: mosd_result.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Update mode fetch returns output register
// - Early fetch repeats data marked stale
// - Ready rises when new data valid, serial outputs only
// - Sleep mode converts once at boot, then only on request
// - Sleep only with serial outputs
// - Wake runs temp, cap, then correction
// - Update register and alarms before sleeping
// - Status sits in top two bits
// - Codes: valid, stale, command mode
// - Fetch before first result reads stale
// - Serial fault reads saturated 3fff values
// - Density fault drives selected density outputs high (temp only in PDMCT)
// - Check config at boot, wake; permanent
// - Cycle faults shown at next delivery
// - Config, RAM, double-bit, overflow fault sources
// - 32 words, 16 data, 6 check
// - Command mode reports both error kinds
// - Normal mode flags only double-bit errors
// - Alarms never carry fault indication
// - Result 14 bits, MSB first
// - Snapshot packet at start, update after
module mosd_result
  import mosd_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Configuration
  input  wire logic [2:0]        out_select,
  input  wire logic              sleep_mode,
  input  wire logic              command_mode,
  // Serial side events from the protocol engine
  input  wire logic              comm_start,
  input  wire logic              comm_end,
  input  wire logic              result_read_cmd,
  input  wire logic              conversion_request_cmd,
  input  wire logic              shift_en,
  // Conversion engine
  input  wire logic              conv_done,
  input  wire logic [RES_W-1:0]  temp_result,
  input  wire logic [RES_W-1:0]  cap_result,
  input  wire logic [RES_W-1:0]  alarm_hi_lim,
  input  wire logic [RES_W-1:0]  alarm_lo_lim,
  input  wire logic              ram_parity_err,
  input  wire logic              math_overflow,
  // Nonvolatile store access
  input  wire logic [NV_AW-1:0]  nv_addr,
  input  wire logic              nv_rd,
  input  wire logic              nv_wr,
  input  wire logic [NV_CW-1:0]  nv_wdata,
  output logic      [NV_DW-1:0]  nv_rdata,
  output logic      [1:0]        nv_resp,
  // Conversion control
  output logic                   powered_up,
  output logic                   conv_temp_go,
  output logic                   conv_cap_go,
  output logic                   corr_go,
  // Result delivery
  output logic                   serial_bit,
  output logic                   ready_out,
  output logic                   alarm_high,
  output logic                   alarm_low,
  output logic                   cap_density_out,
  output logic                   temp_density_out,
  output logic                   fault_out
);

  // ****************************************************************
  // Store and corrector
  // ****************************************************************
  logic [NV_CW-1:0] nv_word;
  logic [NV_DW-1:0] nv_fixed;
  logic             single_bit_fix;
  logic             double_bit_flag;
  logic             nv_rd_q;

  mosd_nvm u_nvm (
    .core_clk (core_clk),
    .reset    (reset),
    .rd_addr  (nv_addr),
    .rd_en    (nv_rd),
    .wr_addr  (nv_addr),
    .wr_en    (nv_wr),
    .wr_word  (nv_wdata),
    .rd_word  (nv_word)
  );

  mosd_ecc u_ecc (
    .code_in         (nv_word),
    .data_out        (nv_fixed),
    .single_bit_fix  (single_bit_fix),
    .double_bit_flag (double_bit_flag)
  );

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      nv_rd_q <= 1'b0;
    end
    else
    begin
      nv_rd_q <= nv_rd;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      nv_rdata <= '0;
      nv_resp  <= 2'h0;
    end
    else if (nv_rd_q && command_mode)
    begin
      nv_rdata <= nv_fixed;
      nv_resp  <= {double_bit_flag, single_bit_fix};
    end
  end

  // ****************************************************************
  // Mode legality
  // ****************************************************************
  logic serial_sel;
  logic density_sel;
  logic sleep_ok;

  assign serial_sel  = (out_select == OSEL_I2C) || (out_select == OSEL_SPI);
  assign density_sel = (out_select == OSEL_PDMC) || (out_select == OSEL_PDMCT);
  assign sleep_ok    = sleep_mode && serial_sel;

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  mosd_state_e state_q;
  logic        req_pend_q;
  logic        spi_block_q;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= ST_BOOT;
    end
    else
    begin
      unique case (state_q)
        ST_BOOT:   state_q <= ST_CHECK;
        ST_IDLE:   if (!sleep_ok || req_pend_q) state_q <= ST_CHECK;
        ST_CHECK:  state_q <= ST_TEMP;
        ST_TEMP:   if (conv_done) state_q <= ST_CAP;
        ST_CAP:    if (conv_done) state_q <= ST_CORR;
        ST_CORR:   if (conv_done) state_q <= ST_UPDATE;
        ST_UPDATE: state_q <= ST_IDLE;
        default:   state_q <= ST_BOOT;
      endcase
    end
  end

  assign powered_up   = (state_q != ST_IDLE) || !sleep_ok;
  assign conv_temp_go = (state_q == ST_CHECK);
  assign conv_cap_go  = (state_q == ST_TEMP) && conv_done;
  assign corr_go      = (state_q == ST_CAP) && conv_done;

  // SPI requests need a fetch first
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      spi_block_q <= 1'b0;
    end
    else if (state_q == ST_UPDATE && out_select == OSEL_SPI)
    begin
      spi_block_q <= 1'b1;
    end
    else if (comm_end && result_read_cmd)
    begin
      spi_block_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      req_pend_q <= 1'b0;
    end
    else if (conversion_request_cmd && comm_end && sleep_ok && !spi_block_q)
    begin
      req_pend_q <= 1'b1;
    end
    else if (state_q == ST_CHECK)
    begin
      req_pend_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Diagnostics
  // ****************************************************************
  logic cfg_fault_q;
  logic cyc_fault_q;
  logic diag_q;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cfg_fault_q <= 1'b0;
    end
    else if (state_q == ST_CHECK && (ram_parity_err || (nv_rd_q && double_bit_flag)))
    begin
      cfg_fault_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset || state_q == ST_CHECK)
    begin
      cyc_fault_q <= 1'b0;
    end
    else if (state_q inside {ST_TEMP, ST_CAP, ST_CORR})
    begin
      if (ram_parity_err || math_overflow || (nv_rd_q && double_bit_flag && !command_mode))
      begin
        cyc_fault_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      diag_q <= 1'b0;
    end
    else if (state_q == ST_UPDATE)
    begin
      diag_q <= cfg_fault_q || cyc_fault_q;
    end
    else if (cfg_fault_q)
    begin
      diag_q <= 1'b1;
    end
  end

  assign fault_out = diag_q;

  // ****************************************************************
  // Output register, status and alarms
  // ****************************************************************
  logic [RES_W-1:0] cap_q;
  logic [RES_W-1:0] temp_q;
  logic             fresh_q;
  logic             ready_q;
  logic             alarm_hi_q;
  logic             alarm_lo_q;
  logic             load;

  assign load = (state_q == ST_UPDATE);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cap_q  <= RES_ZERO;
      temp_q <= RES_ZERO;
    end
    else if (load)
    begin
      cap_q  <= cap_result;
      temp_q <= temp_result;
    end
  end

  // valid until fetch completes, load wins
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      fresh_q <= 1'b0;
    end
    else if (load)
    begin
      fresh_q <= 1'b1;
    end
    else if (comm_end && result_read_cmd)
    begin
      fresh_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= load || (fresh_q && !(comm_end && result_read_cmd));
    end
  end

  assign ready_out = ready_q && serial_sel;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      alarm_hi_q <= 1'b0;
      alarm_lo_q <= 1'b0;
    end
    else if (load)
    begin
      alarm_hi_q <= cap_result > alarm_hi_lim;
      alarm_lo_q <= cap_result < alarm_lo_lim;
    end
  end

  assign alarm_high = alarm_hi_q;
  assign alarm_low  = alarm_lo_q && (out_select != OSEL_PDMCT);

  // ****************************************************************
  // Serial snapshot
  // ****************************************************************
  logic [PKT_W-1:0] pkt_d;
  logic [PKT_W-1:0] shreg_q;
  logic [1:0]       stat;

  always_comb
  begin
    if (command_mode)
    begin
      stat = STAT_CMD;
    end
    else if (fresh_q)
    begin
      stat = STAT_VALID;
    end
    else
    begin
      stat = STAT_STALE;
    end
  end

  always_comb
  begin
    if (diag_q)
    begin
      pkt_d = {stat, RES_SAT, RES_SAT, 2'h0};
    end
    else
    begin
      pkt_d = {stat, cap_q, temp_q, 2'h0};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      shreg_q <= '0;
    end
    else if (comm_start)
    begin
      shreg_q <= pkt_d;
    end
    else if (shift_en)
    begin
      shreg_q <= {shreg_q[PKT_W-2:0], 1'b0};
    end
  end

  assign serial_bit = shreg_q[PKT_W-1];

  // ****************************************************************
  // Density outputs
  // ****************************************************************
  logic [2:0]       div_q;
  logic             tick;
  logic [RES_W:0]   acc_c_q;
  logic [RES_W:0]   acc_t_q;
  logic             cap_density_out_q;
  logic             temp_density_out_q;

  assign tick = (div_q == PDM_DIV_MAX);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= tick ? 3'h0 : div_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      acc_c_q <= '0;
      acc_t_q <= '0;
      cap_density_out_q <= 1'b0;
      temp_density_out_q <= 1'b0;
    end
    else if (tick)
    begin
      acc_c_q <= {1'b0, acc_c_q[RES_W-1:0]} + {1'b0, cap_q};
      acc_t_q <= {1'b0, acc_t_q[RES_W-1:0]} + {1'b0, temp_q};
      cap_density_out_q <= acc_c_q[RES_W];
      temp_density_out_q <= acc_t_q[RES_W];
    end
  end

  assign cap_density_out  = density_sel && (diag_q || cap_density_out_q);
  assign temp_density_out = (out_select == OSEL_PDMCT) && (diag_q || temp_density_out_q);

endmodule : mosd_result
`default_nettype wire

/* File: mosd_result_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module mosd_result_monitor
  import mosd_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset,
  // Configuration and events
  input wire logic [2:0] out_select,
  input wire logic       sleep_mode,
  input wire logic       comm_start,
  input wire logic       comm_end,
  input wire logic       result_read_cmd,
  input wire logic       conversion_request_cmd,
  input wire logic       shift_en,
  input wire logic       conv_done,
  // Observed outputs
  input wire logic       powered_up,
  input wire logic       conv_temp_go,
  input wire logic       conv_cap_go,
  input wire logic       corr_go,
  input wire logic       serial_bit,
  input wire logic       ready_out,
  input wire logic       cap_density_out,
  input wire logic       temp_density_out,
  input wire logic       fault_out
);
  logic ser;
  logic req;
  logic dens;
  assign ser  = (out_select == OSEL_I2C) || (out_select == OSEL_SPI);
  assign dens = (out_select == OSEL_PDMC) || (out_select == OSEL_PDMCT);
  assign req  = comm_end && conversion_request_cmd;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ****
  // Delivery checks
  // ****
  a_fetch_drops_ready: assert property (sleep_mode && ser && comm_end && result_read_cmd |-> ##[1:2] !ready_out)
    else $error("ready stayed high after a fetch");
  a_ready_serial_only: assert property (dens && $past(dens) |-> !ready_out)
    else $error("ready high without serial output");
  a_shift_holds: assert property (!$past(shift_en) && !$past(comm_start) && !$past(reset) |-> $stable(serial_bit))
    else $error("shift register moved without a shift");
  a_density_fault_high: assert property (fault_out && $past(fault_out) && out_select == OSEL_PDMCT
    && $past(out_select) == OSEL_PDMCT |-> cap_density_out && temp_density_out)
    else $error("density outputs not railed on fault");
  // ****
  // Conversion sequencing
  // ****
  // Request latched, then wake one edge later: power shows two edges after it
  a_wake_needs_req: assert property ($rose(powered_up) && sleep_mode && ser && $stable(out_select)
    && $past(sleep_mode) |-> $past(req, 2))
    else $error("woke without a request");
  a_down_stays_down: assert property (sleep_mode && $past(sleep_mode) && ser && $stable(out_select)
    && !$past(powered_up) && !$past(req) && !$past(req, 2) |-> !powered_up)
    else $error("left power-down without a request");
  a_wake_temp_first: assert property ($rose(powered_up) && sleep_mode && ser |-> ##[0:3] conv_temp_go)
    else $error("no temperature start after wake");
  // Engine model ends each phase three cycles after its start
  a_cap_after_temp: assert property (conv_cap_go |-> conv_done && $past(conv_temp_go, 3))
    else $error("capacitance start without a finished phase");
  a_corr_after_cap: assert property (corr_go |-> conv_done && $past(conv_cap_go, 3))
    else $error("correction start without a finished phase");
  a_density_no_sleep: assert property (dens && $past(dens) |-> powered_up)
    else $error("powered down with density output");
endmodule : mosd_result_monitor
bind mosd_result mosd_result_monitor u_mosd_result_monitor (.core_clk, .reset, .out_select, .sleep_mode,
  .comm_start, .comm_end, .result_read_cmd, .conversion_request_cmd, .shift_en, .conv_done, .powered_up,
  .conv_temp_go, .conv_cap_go, .corr_go, .serial_bit, .ready_out, .cap_density_out, .temp_density_out, .fault_out);
`default_nettype wire

/* File: mosd_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mosd_host_model
  import mosd_pkg::*;
(
  // Clock and selection
  input  wire logic       core_clk,
  input  wire logic [2:0] out_select,
  // Device data
  input  wire logic       serial_bit,
  // Command events
  output logic            comm_start,
  output logic            comm_end,
  output logic            result_read_cmd,
  output logic            conversion_request_cmd,
  output logic            shift_en
);
  logic owe_fetch;
  initial {comm_start, comm_end, result_read_cmd, conversion_request_cmd, shift_en, owe_fetch} = '0;
  task automatic fetch(output logic [31:0] pkt);
    @(posedge core_clk) #1 comm_start = 1'b1;
    @(posedge core_clk) #1 comm_start = 1'b0;
    for (int i = 0; i < PKT_W; i++)
    begin
      pkt = {pkt[30:0], serial_bit};
      shift_en = (i < PKT_W - 1);
      @(posedge core_clk) #1;
    end
    {comm_end, result_read_cmd} = 2'b11;
    @(posedge core_clk) #1 {comm_end, result_read_cmd} = 2'b00;
    owe_fetch = 1'b0;
  endtask : fetch
  task automatic request();
    logic [31:0] dummy;
    if (out_select == OSEL_SPI && owe_fetch)
      fetch(dummy);
    @(posedge core_clk) #1 {comm_end, conversion_request_cmd} = 2'b11;
    @(posedge core_clk) #1 {comm_end, conversion_request_cmd} = 2'b00;
    owe_fetch = 1'b1;
  endtask : request
endmodule : mosd_host_model
`default_nettype wire

/* File: mosd_result_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHECK(name, exp, got) \
  begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s expected %h seen %h", name, exp, got); end end
module mosd_result_bench
  import mosd_pkg::*;
;
  typedef struct packed {
    logic [2:0]  osel;
    logic        ovf;
    logic [13:0] cap;
    logic [13:0] temp;
    logic [1:0]  alm;
    logic [31:0] pkt;
  } mosd_row_s;
  logic             core_clk, reset, sleep_mode, command_mode, conv_done, ram_parity_err, math_overflow;
  logic             comm_start, comm_end, result_read_cmd, conversion_request_cmd, shift_en;
  logic             nv_rd, nv_wr, powered_up, conv_temp_go, conv_cap_go, corr_go, serial_bit, ready_out;
  logic             alarm_high, alarm_low, cap_density_out, temp_density_out, fault_out;
  logic [2:0]       out_select;
  logic [2:0]       go_dly = '0;
  logic [13:0]      temp_result, cap_result;
  logic [NV_AW-1:0] nv_addr;
  logic [NV_CW-1:0] nv_wdata;
  logic [15:0]      nv_rdata;
  logic [1:0]       nv_resp;
  logic [31:0]      pkt;
  int               errors = 0;
  int               n_checks = 0;
  mosd_row_s        rows [5] = '{
    '{OSEL_I2C, 1'b0, 14'h2a5c, 14'h0001, 2'b00, {STAT_VALID, 14'h2a5c, 14'h0001, 2'h0}},
    '{OSEL_I2C, 1'b1, 14'h0f0f, 14'h1111, 2'b00, {STAT_VALID, RES_SAT, RES_SAT, 2'h0}},
    '{OSEL_I2C, 1'b0, 14'h0000, 14'h3ffe, 2'b01, {STAT_VALID, 14'h0000, 14'h3ffe, 2'h0}},
    '{OSEL_SPI, 1'b0, 14'h3555, 14'h2aaa, 2'b10, {STAT_VALID, 14'h3555, 14'h2aaa, 2'h0}},
    '{OSEL_SPI, 1'b0, 14'h0100, 14'h2000, 2'b01, {STAT_VALID, 14'h0100, 14'h2000, 2'h0}}};
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Conversion engine: each phase ends three cycles after its start
  always @(posedge core_clk) go_dly <= #1 {go_dly[1:0], conv_temp_go | conv_cap_go | corr_go};
  assign conv_done = go_dly[2];
  mosd_result u_mosd_result (.core_clk, .reset, .out_select, .sleep_mode, .command_mode, .comm_start, .comm_end,
    .result_read_cmd, .conversion_request_cmd, .shift_en, .conv_done, .temp_result, .cap_result,
    .alarm_hi_lim(14'h3000), .alarm_lo_lim(14'h0800), .ram_parity_err, .math_overflow, .nv_addr, .nv_rd,
    .nv_wr, .nv_wdata, .nv_rdata, .nv_resp, .powered_up, .conv_temp_go, .conv_cap_go, .corr_go, .serial_bit,
    .ready_out, .alarm_high, .alarm_low, .cap_density_out, .temp_density_out, .fault_out);
  mosd_host_model u_mosd_host_model (.core_clk, .out_select, .serial_bit, .comm_start, .comm_end,
    .result_read_cmd, .conversion_request_cmd, .shift_en);
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_out !== 1'b1 && n < 300)
    begin
      @(posedge core_clk) #1;
      n++;
    end
    if (n == 300)
    begin
      errors++;
      report_and_stop();
    end
  endtask : wait_ready
  task automatic nv_access(input logic [NV_AW-1:0] a, input logic wr, input logic [NV_CW-1:0] w);
    nv_addr = a;
    nv_wdata = w;
    {nv_wr, nv_rd} = {wr, !wr};
    @(posedge core_clk) #1 {nv_wr, nv_rd} = 2'b00;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : nv_access
  initial
  begin
    {reset, sleep_mode, command_mode, ram_parity_err, math_overflow, nv_rd, nv_wr} = 7'b1100000;
    {out_select, nv_addr, nv_wdata, temp_result, cap_result} = {OSEL_I2C, 5'h00, 22'h0, 14'h0, 14'h0};
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    u_mosd_host_model.fetch(pkt);
    `CHECK("first status", STAT_STALE, pkt[31:30])
    foreach (rows[i])
    begin
      {out_select, math_overflow, cap_result, temp_result} = {rows[i].osel, rows[i].ovf, rows[i].cap, rows[i].temp};
      u_mosd_host_model.request();
      wait_ready();
      u_mosd_host_model.fetch(pkt);
      `CHECK("fresh packet", rows[i].pkt, pkt)
      `CHECK("alarms", rows[i].alm, {alarm_high, alarm_low})
      u_mosd_host_model.fetch(pkt);
      `CHECK("stale packet", {STAT_STALE, rows[i].pkt[29:0]}, pkt)
      `CHECK("ready after fetch", 1'b0, ready_out)
      `CHECK("sleeping", 1'b0, powered_up)
    end
    sleep_mode = 1'b0;
    wait_ready();
    u_mosd_host_model.fetch(pkt);
    `CHECK("update packet", rows[4].pkt, pkt)
    sleep_mode = 1'b1;
    command_mode = 1'b1;
    u_mosd_host_model.fetch(pkt);
    `CHECK("command status", STAT_CMD, pkt[31:30])
    nv_access(5'h03, 1'b1, 22'h000004);
    nv_access(5'h1f, 1'b1, 22'h000006);
    nv_access(5'h03, 1'b0, 22'h0);
    `CHECK("single response", 2'h1, nv_resp)
    `CHECK("corrected data", 16'h0000, nv_rdata)
    nv_access(5'h1f, 1'b0, 22'h0);
    `CHECK("double response", 2'h2, nv_resp)
    command_mode = 1'b0;
    {out_select, math_overflow, nv_rd} = {OSEL_I2C, 1'b0, 1'b1};
    for (int k = 0; k < 2; k++)
    begin
      u_mosd_host_model.request();
      wait_ready();
      nv_rd = 1'b0;
      u_mosd_host_model.fetch(pkt);
      `CHECK("config fault packet", {STAT_VALID, RES_SAT, RES_SAT, 2'h0}, pkt)
    end
    {out_select, sleep_mode} = {OSEL_PDMCT, 1'b0};
    repeat (40) @(posedge core_clk);
    #1;
    for (int k = 0; k < 8; k++)
    begin
      `CHECK("railed density", 2'b11, {cap_density_out, temp_density_out})
      `CHECK("density awake", 1'b1, powered_up)
      @(posedge core_clk) #1;
    end
    reset = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    repeat (40) @(posedge core_clk);
    #1;
    `CHECK("fault cleared by reset", 1'b0, fault_out)
    report_and_stop();
  end
endmodule : mosd_result_bench
`default_nettype wire
